// file: hdl/urc_pkg.sv
// Purpose: shared constants and types of the endpoint receive block
// Assumes: 100 MHz clock, word-addressed register bus
// Notes: register index = {page, offset}; byte address is four times it
package urc_pkg;
  // clock and frame pulse timing
  localparam int unsigned CLK_PERIOD_PS = 10_000;
  localparam int unsigned FRAME_PULSE_PS = 333_330;
  // longest time, so round down, never below one cycle
  localparam int unsigned FRAME_PULSE_CYC =
    (FRAME_PULSE_PS / CLK_PERIOD_PS < 1) ? 1 :
    FRAME_PULSE_PS / CLK_PERIOD_PS;
  localparam logic [1:0] SOF_LOCK_CNT = 2'h2;
  // register pages
  localparam logic [7:0] PAGE_EP_LO = 8'h04;
  localparam logic [7:0] PAGE_EP_HI = 8'h05;
  localparam logic [7:0] PAGE_LINK = 8'h0F;
  localparam logic [7:0] PAGE_MISC = 8'h3C;
  // offsets inside a page
  localparam logic [3:0] EP_ROW_NIB = 4'hF;
  localparam logic [7:0] EP_RX_BASE = 8'hF1;
  localparam logic [7:0] CFG1_OFS = 8'hF4;
  localparam logic [7:0] CFG2_OFS = 8'hF5;
  localparam logic [7:0] MIRA_OFS = 8'hF6;
  localparam logic [7:0] MIRB_OFS = 8'hF7;
  localparam logic [7:0] LINK_CTL_OFS = 8'hFC;
  // reset values
  localparam logic [7:0] EP_RX_RST = 8'h00;
  localparam logic [7:0] CFG1_RST = 8'h0F;
  localparam logic [7:0] CFG2_RST = 8'h00;
  localparam logic [7:0] LINK_CTL_RST = 8'h01;
  localparam logic [7:0] MIRROR_RST = 8'h00;
  // endpoint receive control fields
  localparam int unsigned SSE_BIT = 7;
  localparam int unsigned TOG_BIT = 6;
  localparam int unsigned STAT_HI = 5;
  localparam int unsigned STAT_LO = 4;
  localparam int unsigned EPN_HI = 3;
  // configuration fields
  localparam int unsigned CFG1_OE_BIT = 5;
  localparam logic [3:0] CFG1_ONES = 4'hF;
  localparam int unsigned CFG2_INH_BIT = 1;
  localparam int unsigned CFG2_SOF_BIT = 0;
  localparam int unsigned LINK_FORCED_USB_RESET_BIT = 0;
  // receive status codes
  localparam logic [1:0] ST_DIS = 2'h0;
  localparam logic [1:0] ST_STALL = 2'h1;
  localparam logic [1:0] ST_NAK = 2'h2;
  localparam logic [1:0] ST_VALID = 2'h3;
  // handshake answered to the host
  typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} urc_hs_t;
endpackage : urc_pkg

// file: hdl/urc_top.sv
// Purpose: receive control of 16 endpoints plus config and mirror regs
// Assumes: serial engine on mclk_i hands over one decoded rx request
// Notes: Avalon-MM slave answers every access after one wait cycle
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ns
// How it works
// - expect-status bit stalls OUT carrying data
// - bit clear, OUT of any length accepted
// - toggle inverts on ACK of matching packet
// - SETUP on control endpoint clears toggle
// - isochronous toggle swaps buffer every good packet in status valid
// - status 00 ignore, 01 stall, 10 nak, 11 valid
// - good OUT or SETUP sets status NAK
// - isochronous status never changed by hardware
// - match token number to endpoint number field
// - bus or forced reset clears receive registers
// - enable bit gates upstream output enable pin
// - config one reads 0Fh pattern, bit7 zero
// - dip detector resets only while not inhibited
// - inhibit bit is set-only until reset
// - frame pulse 330 ns (33 cycles) at each frame start
// - pulse needs two SOFs, stops in suspend
// - mirror registers read back bit reversed
// - done flag forces NAK except on isochronous endpoints, SETUP ignored
// - stalled control endpoint still takes SETUP
module urc_top
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // register bus
  input wire logic [15:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // decoded receive request from the serial engine
  input wire logic rx_req_i,
  input wire logic rx_setup_i,
  input wire logic [3:0] rx_ep_i,
  input wire logic rx_data1_i,
  input wire logic rx_nonzero_i,
  input wire logic rx_crc_ok_i,
  // per endpoint state kept by the transmit side
  input wire logic [15:0] ep_control_i,
  input wire logic [15:0] ep_iso_i,
  input wire logic [15:0] xfer_done_i,
  // bus events
  input wire logic usb_reset_i,
  input wire logic usb_resume_i,
  input wire logic sof_rx_i,
  input wire logic frame_start_i,
  input wire logic suspend_i,
  input wire logic usb_oe_i,
  // asynchronous pins
  input wire logic ext_reset_pin_n_i,
  input wire logic supply_dip_i,
  // answer to the serial engine
  output logic hs_valid_o,
  output urc_pkg::urc_hs_t hs_code_o,
  output logic rx_ok_o,
  output logic [3:0] rx_ok_ep_o,
  // alternate function pins and reset request
  output logic usb_oe_pin_o,
  output logic usb_oe_pin_en_o,
  output logic frame_pulse_pin_o,
  output logic frame_pulse_pin_en_o,
  output logic core_reset_req_o
);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  // bit reversal for the mirror registers
  function automatic logic [7:0] bit_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : bit_rev8

  logic [7:0] ep_rx_r [16]; // endpoint receive control
  logic cfg1_oe_r; // upstream oe enable
  logic inhibit_r; // brownout reset inhibit
  logic sof_en_r; // frame pulse enable
  logic forced_usb_reset_r; // forced usb reset
  logic [7:0] mira_r; // last byte written, mirror a
  logic [7:0] mirb_r; // last byte written, mirror b
  logic wait_r; // waitrequest
  logic [31:0] rdata_r; // read data
  logic [1:0] ext_sync_r; // reset pin synchroniser
  logic [1:0] dip_sync_r; // dip detector synchroniser
  logic [1:0] sof_cnt_r; // SOFs seen since reset/resume
  logic [5:0] pulse_cnt_r; // frame pulse remaining cycles
  logic [5:0] pulse_cnt_nxt;
  logic [7:0] rd_data; // read mux
  logic [3:0] ep_idx; // addressed endpoint
  logic ep_sel; // endpoint register addressed
  logic clr_all; // bus or forced reset

  wire logic [7:0] page = avs_address_i[15:8];
  wire logic [7:0] ofs = avs_address_i[7:0];
  wire logic [7:0] wd = avs_writedata_i[7:0];
  // write lands on the edge where waitrequest is seen low
  wire logic wr_en = avs_write_i && !wait_r && avs_byteenable_i[0];
  wire logic misc_pg = (page == urc_pkg::PAGE_MISC);

  assign clr_all = usb_reset_i || forced_usb_reset_r;

  // address decode and read mux; unmapped reads give zero
  always_comb
  begin
    ep_sel = 1'b0;
    ep_idx = 4'h0;
    rd_data = 8'h00;
    if ((page == urc_pkg::PAGE_EP_LO || page == urc_pkg::PAGE_EP_HI) &&
        ofs[0] && ofs[7:4] == urc_pkg::EP_ROW_NIB)
    begin
      // odd offsets from the base, low page first
      ep_sel = 1'b1;
      ep_idx = {page[0], ofs[3:1]};
      rd_data = ep_rx_r[ep_idx];
    end
    else if (misc_pg && ofs == urc_pkg::CFG1_OFS)
    begin
      // fixed ones below, bit 7 and bit 6 read zero
      rd_data = {2'h0, cfg1_oe_r, 1'b0, urc_pkg::CFG1_ONES};
    end
    else if (misc_pg && ofs == urc_pkg::CFG2_OFS)
    begin
      rd_data = {6'h00, inhibit_r, sof_en_r};
    end
    else if (misc_pg && ofs == urc_pkg::MIRA_OFS)
    begin
      rd_data = bit_rev8(mira_r);
    end
    else if (misc_pg && ofs == urc_pkg::MIRB_OFS)
    begin
      rd_data = bit_rev8(mirb_r);
    end
    else if (page == urc_pkg::PAGE_LINK && ofs == urc_pkg::LINK_CTL_OFS)
    begin
      rd_data = {7'h00, forced_usb_reset_r};
    end
  end

  // one wait cycle per access, then release for one cycle
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      wait_r <= 1'b1;
    else
      wait_r <= !((avs_read_i || avs_write_i) && wait_r);
  end

  // read data captured during the wait cycle, held afterwards
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_r <= 32'h0000_0000;
    else if (avs_read_i && wait_r)
      rdata_r <= {24'h00_0000, rd_data};
  end

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o = rdata_r;

  // configuration registers; software keeps them steady once set
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cfg1_oe_r <= urc_pkg::CFG1_RST[urc_pkg::CFG1_OE_BIT];
      inhibit_r <= urc_pkg::CFG2_RST[urc_pkg::CFG2_INH_BIT];
      sof_en_r <= urc_pkg::CFG2_RST[urc_pkg::CFG2_SOF_BIT];
      forced_usb_reset_r <= urc_pkg::LINK_CTL_RST[urc_pkg::LINK_FORCED_USB_RESET_BIT];
    end
    else if (wr_en)
    begin
      if (misc_pg && ofs == urc_pkg::CFG1_OFS)
        cfg1_oe_r <= wd[urc_pkg::CFG1_OE_BIT];
      if (misc_pg && ofs == urc_pkg::CFG2_OFS)
      begin
        // a zero written is ignored; only device reset clears it
        inhibit_r <= inhibit_r | wd[urc_pkg::CFG2_INH_BIT];
        sof_en_r <= wd[urc_pkg::CFG2_SOF_BIT];
      end
      if (page == urc_pkg::PAGE_LINK && ofs == urc_pkg::LINK_CTL_OFS)
        forced_usb_reset_r <= wd[urc_pkg::LINK_FORCED_USB_RESET_BIT];
    end
  end

  // mirror registers keep the raw byte
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mira_r <= urc_pkg::MIRROR_RST;
      mirb_r <= urc_pkg::MIRROR_RST;
    end
    else if (wr_en && misc_pg)
    begin
      if (ofs == urc_pkg::MIRA_OFS)
        mira_r <= wd;
      if (ofs == urc_pkg::MIRB_OFS)
        mirb_r <= wd;
    end
  end

  // endpoint lookup: enabled endpoints whose number matches
  logic [15:0] match;
  for (genvar e = 0; e < 16; e++)
  begin : g_match
    assign match[e] = (ep_rx_r[e][urc_pkg::EPN_HI:0] == rx_ep_i) &&
      (ep_rx_r[e][urc_pkg::STAT_HI:urc_pkg::STAT_LO] != urc_pkg::ST_DIS);
  end

  logic found; // some endpoint takes the request
  logic [3:0] sel; // lowest matching endpoint
  always_comb
  begin
    found = 1'b0;
    sel = 4'h0;
    for (int e = 15; e >= 0; e--)
    begin
      if (match[e])
      begin
        found = 1'b1;
        sel = 4'(e);
      end
    end
  end

  wire logic [7:0] cur = ep_rx_r[sel];
  wire logic [1:0] st = cur[urc_pkg::STAT_HI:urc_pkg::STAT_LO];
  wire logic tog = cur[urc_pkg::TOG_BIT];
  wire logic iso = ep_iso_i[sel];
  wire logic ctl = ep_control_i[sel];
  wire logic done = xfer_done_i[sel];

  // handshake decision and register update for one request
  urc_pkg::urc_hs_t hs_nxt;
  logic upd; // endpoint register changes
  logic [7:0] ep_new;
  logic ok_nxt; // correct transfer event
  always_comb
  begin
    hs_nxt = urc_pkg::HS_NONE;
    upd = 1'b0;
    ep_new = cur;
    ok_nxt = 1'b0;
    if (!rx_req_i || !found)
      hs_nxt = urc_pkg::HS_NONE;
    else if (rx_setup_i)
    begin
      // non-control, NAK-state or busy endpoints stay silent
      if (ctl && !done && (st == urc_pkg::ST_VALID ||
          st == urc_pkg::ST_STALL) && rx_crc_ok_i)
      begin
        hs_nxt = urc_pkg::HS_ACK;
        upd = 1'b1;
        ep_new[urc_pkg::TOG_BIT] = 1'b0;
        ep_new[urc_pkg::STAT_HI:urc_pkg::STAT_LO] = urc_pkg::ST_NAK;
        ok_nxt = 1'b1;
      end
    end
    else if (iso)
    begin
      // no handshake; swap buffer, status left alone
      if (st == urc_pkg::ST_VALID && rx_crc_ok_i)
      begin
        upd = 1'b1;
        ep_new[urc_pkg::TOG_BIT] = !tog;
        ok_nxt = 1'b1;
      end
    end
    else if (done)
      hs_nxt = urc_pkg::HS_NAK;
    else if (st == urc_pkg::ST_STALL)
      hs_nxt = urc_pkg::HS_STALL;
    else if (st == urc_pkg::ST_NAK)
      hs_nxt = urc_pkg::HS_NAK;
    else if (!rx_crc_ok_i)
      hs_nxt = urc_pkg::HS_NONE;
    else if (cur[urc_pkg::SSE_BIT] && rx_nonzero_i)
      hs_nxt = urc_pkg::HS_STALL;
    else if (rx_data1_i != tog)
      hs_nxt = urc_pkg::HS_ACK; // resent packet, data dropped
    else
    begin
      // any length accepted when status stage not expected
      hs_nxt = urc_pkg::HS_ACK;
      upd = 1'b1;
      ep_new[urc_pkg::TOG_BIT] = !tog;
      ep_new[urc_pkg::STAT_HI:urc_pkg::STAT_LO] = urc_pkg::ST_NAK;
      ok_nxt = 1'b1;
    end
  end

  // endpoint registers: reset, then hardware update, then software
  // hardware wins a same-cycle clash so a received packet is not lost
  for (genvar e = 0; e < 16; e++)
  begin : g_ep
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
      if (!resetn_i)
        ep_rx_r[e] <= urc_pkg::EP_RX_RST;
      else if (clr_all)
        ep_rx_r[e] <= urc_pkg::EP_RX_RST;
      else if (upd && sel == 4'(e))
        ep_rx_r[e] <= ep_new;
      else if (wr_en && ep_sel && ep_idx == 4'(e))
        ep_rx_r[e] <= wd;
    end
  end

  // answer to the serial engine, one cycle after the request
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      hs_valid_o <= 1'b0;
      hs_code_o <= urc_pkg::HS_NONE;
      rx_ok_o <= 1'b0;
      rx_ok_ep_o <= 4'h0;
    end
    else
    begin
      hs_valid_o <= rx_req_i;
      hs_code_o <= hs_nxt;
      rx_ok_o <= ok_nxt;
      if (rx_req_i)
        rx_ok_ep_o <= sel;
    end
  end

  // upstream output enable gated onto its pin
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      usb_oe_pin_o <= 1'b0;
      usb_oe_pin_en_o <= 1'b0;
    end
    else
    begin
      usb_oe_pin_o <= cfg1_oe_r && usb_oe_i;
      usb_oe_pin_en_o <= cfg1_oe_r;
    end
  end

  // pin synchronisers; reset pin idles high
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ext_sync_r <= 2'h3;
      dip_sync_r <= 2'h0;
    end
    else
    begin
      ext_sync_r <= {ext_sync_r[0], ext_reset_pin_n_i};
      dip_sync_r <= {dip_sync_r[0], supply_dip_i};
    end
  end

  // reset request: pin always, dip detector unless inhibited
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      core_reset_req_o <= 1'b0;
    else
      core_reset_req_o <= !ext_sync_r[1] ||
        (dip_sync_r[1] && !inhibit_r);
  end

  // frame timer lock: two SOFs after bus reset or resume
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      sof_cnt_r <= 2'h0;
    else if (clr_all || usb_resume_i)
      sof_cnt_r <= 2'h0;
    else if (sof_rx_i && sof_cnt_r != urc_pkg::SOF_LOCK_CNT)
      sof_cnt_r <= sof_cnt_r + 2'h1;
  end

  wire logic locked = (sof_cnt_r == urc_pkg::SOF_LOCK_CNT);

  // pulse length counter; suspend cuts it at once
  always_comb
  begin
    pulse_cnt_nxt = pulse_cnt_r;
    if (suspend_i || !sof_en_r)
      pulse_cnt_nxt = 6'h00;
    else if (frame_start_i && locked)
      pulse_cnt_nxt = 6'(urc_pkg::FRAME_PULSE_CYC);
    else if (pulse_cnt_r != 6'h00)
      pulse_cnt_nxt = pulse_cnt_r - 6'h01;
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pulse_cnt_r <= 6'h00;
      frame_pulse_pin_o <= 1'b0;
      frame_pulse_pin_en_o <= 1'b0;
    end
    else
    begin
      pulse_cnt_r <= pulse_cnt_nxt;
      frame_pulse_pin_o <= (pulse_cnt_nxt != 6'h00);
      frame_pulse_pin_en_o <= sof_en_r;
    end
  end

  // checks
  wire logic out_live = rx_req_i && found && !rx_setup_i && !iso &&
    !done && st == urc_pkg::ST_VALID && rx_crc_ok_i && !clr_all;
  logic any_ep_set;
  always_comb
  begin
    any_ep_set = 1'b0;
    for (int e = 0; e < 16; e++)
      any_ep_set = any_ep_set || (ep_rx_r[e] != 8'h00);
  end

  a_stall_data: assert property (
    out_live && cur[urc_pkg::SSE_BIT] && rx_nonzero_i |=>
      hs_code_o == urc_pkg::HS_STALL && !rx_ok_o)
    else $error("data OUT not stalled in status stage");
  a_accept_len: assert property (
    out_live && !cur[urc_pkg::SSE_BIT] && rx_data1_i == tog |=>
      hs_valid_o && hs_code_o == urc_pkg::HS_ACK && rx_ok_o)
    else $error("OUT not accepted");
  a_toggle_flip: assert property (
    out_live && !cur[urc_pkg::SSE_BIT] && rx_data1_i == tog |=>
      ep_rx_r[rx_ok_ep_o][urc_pkg::TOG_BIT] != $past(tog))
    else $error("toggle not inverted after ACK");
  a_setup_tog: assert property (
    ok_nxt && rx_setup_i && !clr_all |=>
      !ep_rx_r[rx_ok_ep_o][urc_pkg::TOG_BIT])
    else $error("toggle not cleared by SETUP");
  sequence s_iso_pkt;
    rx_req_i && found && !rx_setup_i && iso && !clr_all &&
      st == urc_pkg::ST_VALID && rx_crc_ok_i;
  endsequence
  a_iso_swap: assert property (
    s_iso_pkt |=> hs_code_o == urc_pkg::HS_NONE &&
      ep_rx_r[rx_ok_ep_o][urc_pkg::TOG_BIT] != $past(tog) &&
      ep_rx_r[rx_ok_ep_o][urc_pkg::STAT_HI:urc_pkg::STAT_LO] ==
        urc_pkg::ST_VALID)
    else $error("isochronous swap wrong");
  // iso type taken from the request cycle, not the released fields
  a_nak_after: assert property (
    rx_ok_o && !$past(iso) && !$past(clr_all) |->
      ep_rx_r[rx_ok_ep_o][urc_pkg::STAT_HI:urc_pkg::STAT_LO] ==
        urc_pkg::ST_NAK)
    else $error("status not NAK after transfer");
  a_no_target: assert property (
    rx_req_i && !found |=> hs_valid_o && hs_code_o == urc_pkg::HS_NONE)
    else $error("answer without matching endpoint");
  a_done_nak: assert property (
    rx_req_i && found && !rx_setup_i && !iso && done |=>
      hs_code_o == urc_pkg::HS_NAK && !rx_ok_o)
    else $error("busy endpoint not NAKed");
  a_rst_clear: assert property (
    clr_all |=> !any_ep_set)
    else $error("receive registers not cleared");
  a_oe_gate: assert property (
    !cfg1_oe_r |=> !usb_oe_pin_o && !usb_oe_pin_en_o)
    else $error("oe pin active while disabled");
  a_inhibit_hold: assert property (
    inhibit_r |=> inhibit_r) else $error("inhibit bit cleared");
  a_dip_masked: assert property (
    inhibit_r && ext_sync_r[1] |=> !core_reset_req_o)
    else $error("dip reset while inhibited");
  sequence s_pulse_arm;
    frame_start_i && locked && sof_en_r && !suspend_i
      ##1 (!suspend_i && sof_en_r)[*7];
  endsequence
  a_pulse_hold: assert property (
    s_pulse_arm |=> frame_pulse_pin_o)
    else $error("frame pulse ended early");
  a_pulse_lock: assert property (
    $rose(frame_pulse_pin_o) |-> $past(locked) && !$past(suspend_i))
    else $error("frame pulse before lock or in suspend");

endmodule : urc_top

// file: test/urc_host_model.sv
// Purpose: upstream host model issuing decoded receive transactions
// Assumes: the block answers one cycle after the request edge
// Notes: released fields turn to junk so stale values cannot pass
`timescale 1ns/1ns
module urc_host_model
(
  // clock
  input wire logic mclk_i,
  // request towards the block
  output logic rx_req_o,
  output logic rx_setup_o,
  output logic [3:0] rx_ep_o,
  output logic rx_data1_o,
  output logic rx_nonzero_o,
  output logic rx_crc_ok_o,
  // answer from the block
  input wire logic hs_valid_i,
  input wire urc_pkg::urc_hs_t hs_code_i,
  input wire logic rx_ok_i
);
  // idle bus at time zero
  initial
  begin
    rx_req_o = 1'b0;
    rx_setup_o = 1'b0;
    rx_ep_o = 4'hF;
    rx_data1_o = 1'b0;
    rx_nonzero_o = 1'b0;
    rx_crc_ok_o = 1'b0;
  end

  // one transaction; answer is {valid, ok, code}
  task automatic send(input logic stp, input logic [3:0] ep,
    input logic d1, input logic nz, input logic crc,
    output logic [3:0] ans);
    @(posedge mclk_i);
    rx_req_o <= 1'b1;
    rx_setup_o <= stp;
    rx_ep_o <= ep;
    rx_data1_o <= d1;
    rx_nonzero_o <= nz;
    rx_crc_ok_o <= crc;
    @(posedge mclk_i);
    rx_req_o <= 1'b0;
    // released fields invert, the block must not reuse them
    rx_setup_o <= ~stp;
    rx_ep_o <= ~ep;
    rx_data1_o <= ~d1;
    rx_nonzero_o <= ~nz;
    rx_crc_ok_o <= ~crc;
    // answer stands one cycle only
    @(negedge mclk_i);
    ans = {hs_valid_i, rx_ok_i, hs_code_i};
  endtask : send
endmodule : urc_host_model

// file: test/urc_top_tb.sv
// Purpose: self-checking bench of the endpoint receive block
// Assumes: random stimulus with seed 54, register bus with waitrequest
// Notes: answers and most pins are sampled on the falling edge; bus read data and the frame pulse enable on the rising edge
`timescale 1ns/1ns
module urc_top_tb;
  // clock, reset and register bus
  logic mclk_i, resetn_i, avs_read_i, avs_write_i;
  logic [15:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic avs_waitrequest_o;
  // receive request lines and answer
  logic rx_req_i, rx_setup_i, rx_data1_i, rx_nonzero_i, rx_crc_ok_i;
  logic [3:0] rx_ep_i, rx_ok_ep_o;
  logic hs_valid_o, rx_ok_o;
  urc_pkg::urc_hs_t hs_code_o;
  // endpoint state and bus events
  logic [15:0] ep_control_i, ep_iso_i, xfer_done_i;
  logic usb_reset_i, usb_resume_i, sof_rx_i, frame_start_i, suspend_i;
  logic usb_oe_i, ext_reset_pin_n_i, supply_dip_i;
  // pins
  logic usb_oe_pin_o, usb_oe_pin_en_o, frame_pulse_pin_o;
  logic frame_pulse_pin_en_o, core_reset_req_o;
  // bench state
  int mismatches, n_checks;
  logic [7:0] q, d;
  logic [3:0] r;

  urc_top u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rx_req_i(rx_req_i),
    .rx_setup_i(rx_setup_i), .rx_ep_i(rx_ep_i), .rx_data1_i(rx_data1_i),
    .rx_nonzero_i(rx_nonzero_i), .rx_crc_ok_i(rx_crc_ok_i),
    .ep_control_i(ep_control_i), .ep_iso_i(ep_iso_i),
    .xfer_done_i(xfer_done_i), .usb_reset_i(usb_reset_i),
    .usb_resume_i(usb_resume_i), .sof_rx_i(sof_rx_i),
    .frame_start_i(frame_start_i), .suspend_i(suspend_i),
    .usb_oe_i(usb_oe_i), .ext_reset_pin_n_i(ext_reset_pin_n_i),
    .supply_dip_i(supply_dip_i), .hs_valid_o(hs_valid_o),
    .hs_code_o(hs_code_o), .rx_ok_o(rx_ok_o), .rx_ok_ep_o(rx_ok_ep_o),
    .usb_oe_pin_o(usb_oe_pin_o), .usb_oe_pin_en_o(usb_oe_pin_en_o),
    .frame_pulse_pin_o(frame_pulse_pin_o),
    .frame_pulse_pin_en_o(frame_pulse_pin_en_o),
    .core_reset_req_o(core_reset_req_o));

  urc_host_model u_host (.mclk_i(mclk_i), .rx_req_o(rx_req_i),
    .rx_setup_o(rx_setup_i), .rx_ep_o(rx_ep_i), .rx_data1_o(rx_data1_i),
    .rx_nonzero_o(rx_nonzero_i), .rx_crc_ok_o(rx_crc_ok_i),
    .hs_valid_i(hs_valid_o), .hs_code_i(hs_code_o), .rx_ok_i(rx_ok_o));

  // 100 MHz clock
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // compare seen against expected
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one register access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [15:0] a,
    input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_writedata_i <= 32'(wd);
    n = 0;
    @(posedge mclk_i);
    // waitrequest seen at the edge, before the slave updates it
    while (avs_waitrequest_o !== 1'b0 && n < 20)
    begin
      @(posedge mclk_i);
      n++;
    end
    rd = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    // a hung slave ends the run
    if (n >= 20)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask : bus

  task automatic wr(input logic [15:0] a, input logic [7:0] wd);
    logic [7:0] x;
    bus(1'b1, a, wd, x);
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] x;
    bus(1'b0, a, 8'h00, x);
    chk(x, exp);
  endtask : rdc

  // one receive transaction checked as {valid, ok, code}
  task automatic rx(input logic stp, input logic [3:0] ep, input logic d1,
    input logic nz, input logic [3:0] exp);
    logic [3:0] ans;
    u_host.send(stp, ep, d1, nz, 1'b1, ans);
    chk({4'h0, ans}, {4'h0, exp});
  endtask : rx

  // frame start mark, then count pulse cycles on the pin
  task automatic fp(input logic [7:0] exp);
    logic [7:0] cnt;
    @(posedge mclk_i);
    frame_start_i <= 1'b1;
    @(posedge mclk_i);
    frame_start_i <= 1'b0;
    cnt = 8'h00;
    repeat (60)
    begin
      @(negedge mclk_i);
      cnt = cnt + 8'(frame_pulse_pin_o === 1'b1);
    end
    chk(cnt, exp);
  endtask : fp

  // endpoint register index: page 4 or 5, odd offsets
  function automatic logic [15:0] epa(input int n);
    return {(n < 8) ? 8'h04 : 8'h05, 8'hF1 + 8'(2 * (n % 8))};
  endfunction : epa

  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      rev[i] = v[7 - i];
  endfunction : rev

  // handshake expected for each status code
  function automatic logic [3:0] exp_of(input logic [1:0] st);
    case (st)
      urc_pkg::ST_DIS: return {2'b10, urc_pkg::HS_NONE};
      urc_pkg::ST_STALL: return {2'b10, urc_pkg::HS_STALL};
      urc_pkg::ST_NAK: return {2'b10, urc_pkg::HS_NAK};
      default: return {2'b11, urc_pkg::HS_ACK};
    endcase
  endfunction : exp_of

  // main sequence
  initial
  begin
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    {ep_control_i, ep_iso_i, xfer_done_i} = '0;
    {usb_reset_i, usb_resume_i, sof_rx_i, frame_start_i} = '0;
    {suspend_i, supply_dip_i} = '0;
    usb_oe_i = 1'b1;
    ext_reset_pin_n_i = 1'b1;
    mismatches = 0;
    n_checks = 0;
    resetn_i = 1'b0;
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    void'($urandom(54));
    rdc(16'h3CF4, 8'h0F);
    rdc(16'h3CF5, 8'h00);
    rdc(epa(9), 8'h00);
    // dip detector resets while not inhibited
    supply_dip_i <= 1'b1;
    repeat (6) @(negedge mclk_i);
    chk({7'h0, core_reset_req_o}, 8'h01);
    @(posedge mclk_i);
    supply_dip_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    wr(16'h3CF5, 8'h03);
    wr(16'h3CF5, 8'h01);
    rdc(16'h3CF5, 8'h03);
    supply_dip_i <= 1'b1;
    repeat (6) @(negedge mclk_i);
    chk({7'h0, core_reset_req_o}, 8'h00);
    @(posedge mclk_i);
    supply_dip_i <= 1'b0;
    wr(16'h3CF4, 8'hA0);
    rdc(16'h3CF4, 8'h2F);
    @(negedge mclk_i);
    chk({6'h0, usb_oe_pin_en_o, usb_oe_pin_o}, 8'h03);
    wr(16'h3CF4, 8'h0F);
    repeat (2) @(negedge mclk_i);
    chk({6'h0, usb_oe_pin_en_o, usb_oe_pin_o}, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      d = 8'($urandom);
      wr(16'h3CF6 + 16'(i % 2), d);
      rdc(16'h3CF6 + 16'(i % 2), rev(d));
    end
    wr(16'h3CF8, 8'h5A);
    rdc(16'h3CF8, 8'h00);
    // release forced bus reset, then control endpoint 0
    wr(16'h0FFC, 8'h00);
    ep_control_i <= 16'h0001;
    wr(epa(0), 8'h70);
    rx(1'b1, 4'h0, 1'b0, 1'b1, {2'b11, urc_pkg::HS_ACK});
    rdc(epa(0), 8'h20);
    rx(1'b1, 4'h0, 1'b0, 1'b1, {2'b10, urc_pkg::HS_NONE});
    wr(epa(0), 8'h50);
    rx(1'b1, 4'h0, 1'b0, 1'b1, {2'b11, urc_pkg::HS_ACK});
    rdc(epa(0), 8'h20);
    // endpoint 1 under a random number, every status code
    r = 4'(2 + $urandom_range(13));
    for (int s = 0; s < 4; s++)
    begin
      wr(epa(1), {2'b00, 2'(s), r});
      rx(1'b0, r, 1'b0, 1'b1, exp_of(2'(s)));
      rdc(epa(1), (s == 3) ? {2'b01, urc_pkg::ST_NAK, r} :
        {2'b00, 2'(s), r});
    end
    wr(epa(1), {2'b00, urc_pkg::ST_VALID, r});
    xfer_done_i <= 16'h0002;
    rx(1'b0, r, 1'b0, 1'b1, {2'b10, urc_pkg::HS_NAK});
    chk({4'h0, rx_ok_ep_o}, 8'h01);
    wr(epa(1), {2'b10, urc_pkg::ST_VALID, r});
    xfer_done_i <= 16'h0000;
    // damaged packet: no answer, toggle kept
    q = 8'h00;
    u_host.send(1'b0, r, 1'b0, 1'b1, 1'b0, q[3:0]);
    chk(q, {4'h0, 2'b10, urc_pkg::HS_NONE});
    rx(1'b0, r, 1'b0, 1'b1, {2'b10, urc_pkg::HS_STALL});
    rx(1'b0, r ^ 4'h1, 1'b0, 1'b1, {2'b10, urc_pkg::HS_NONE});
    rx(1'b0, r, 1'b0, 1'b0, {2'b11, urc_pkg::HS_ACK});
    // isochronous: DATA0 only, toggle swaps, status kept
    wr(epa(1), {2'b00, urc_pkg::ST_VALID, r});
    ep_iso_i <= 16'h0002;
    for (int k = 1; k >= 0; k--)
    begin
      rx(1'b0, r, 1'b0, 1'b1, {2'b11, urc_pkg::HS_NONE});
      rdc(epa(1), {1'b0, 1'(k), urc_pkg::ST_VALID, r});
    end
    usb_reset_i <= 1'b1;
    @(posedge mclk_i);
    usb_reset_i <= 1'b0;
    rdc(epa(1), 8'h00);
    // frame pulse needs two frame packets after a bus reset
    fp(8'h00);
    repeat (2)
    begin
      sof_rx_i <= 1'b1;
      @(posedge mclk_i);
      sof_rx_i <= 1'b0;
      @(posedge mclk_i);
    end
    chk({7'h0, frame_pulse_pin_en_o}, 8'h01);
    fp(8'(urc_pkg::FRAME_PULSE_CYC));
    @(posedge mclk_i);
    suspend_i <= 1'b1;
    fp(8'h00);
    // resume unlocks the frame timer again
    @(posedge mclk_i);
    suspend_i <= 1'b0;
    usb_resume_i <= 1'b1;
    @(posedge mclk_i);
    usb_resume_i <= 1'b0;
    fp(8'h00);
    report_and_stop();
  end
endmodule : urc_top_tb
